//--- src/auto_byte_mover.sv
// Automatic byte mover, transfer modes 0 to 7: sequencer, bus master, counter.
// Assumes a core bus that answers each request with a one-cycle bus_ack.
`timescale 1ns/1ps
module auto_byte_mover (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Configuration
  input  wire logic [3:0]  mover_control_a,
  input  wire logic        ptr_a_write,
  input  wire logic [1:0]  mem_ptr_a_high,
  input  wire logic [7:0]  mem_ptr_a_mid,
  input  wire logic [7:0]  mem_ptr_a_low,
  input  wire logic        ptr_b_write,
  input  wire logic [7:0]  mem_ptr_b_low,
  input  wire logic        count_write,
  input  wire logic [7:0]  count_value,
  // Activation
  input  wire logic        act_req,
  // Core bus
  input  wire logic        bus_ack,
  input  wire logic [7:0]  bus_rdata,
  output logic             bus_hold,
  output logic             bus_req,
  output logic             bus_wr,
  output logic      [17:0] bus_addr,
  output logic      [7:0]  bus_wdata,
  output logic             bus_io,
  // Status
  output logic      [17:0] mem_ptr_a,
  output logic      [7:0]  transfer_count_reg,
  output logic             mover_done_irq
);

  mover_step_if step ();

  mover_pkg::state_t state;
  mover_pkg::state_t next_state;
  logic       [3:0]  active_mode;
  logic              byte_sel;
  logic              pending;
  logic       [7:0]  io_ptr;

  step_decode u_decode (
    .step (step)
  );

  // Mode is latched at start so a rewrite mid-activation cannot split a word
  assign step.mode        = (state == mover_pkg::ST_IDLE) ? mover_control_a : active_mode;
  assign step.second_byte = byte_sel;

  wire        count_ok  = (transfer_count_reg != mover_pkg::COUNT_RESET);
  wire        in_idle   = (state == mover_pkg::ST_IDLE);
  wire        start     = in_idle & pending & count_ok & step.valid_mode;
  wire        load_ack  = (state == mover_pkg::ST_LOAD) & bus_ack;
  wire        store_ack = (state == mover_pkg::ST_STORE) & bus_ack;
  wire        more      = store_ack & step.two_bytes & ~byte_sel;
  wire        finish    = store_ack & ~more;
  wire        ptr_inc   = store_ack & step.inc_after;
  wire        last_one  = (transfer_count_reg == mover_pkg::COUNT_LAST);

  // Odd partner is pointer plus one; an odd pointer would carry, hence even only
  wire [7:0]  io_low    = step.io_odd ? 8'(io_ptr + 8'h01) : io_ptr;
  wire [17:0] io_addr   = {mover_pkg::IO_PAGE, io_low};
  wire [17:0] src_addr  = step.io_to_mem ? io_addr : mem_ptr_a;
  wire [17:0] dst_addr  = step.io_to_mem ? mem_ptr_a : io_addr;
  wire [17:0] ptr_a_in  = {mem_ptr_a_high, mem_ptr_a_mid, mem_ptr_a_low};
  wire        next_busy = (next_state != mover_pkg::ST_IDLE);
  wire        next_req  = (next_state == mover_pkg::ST_LOAD) | (next_state == mover_pkg::ST_STORE);

  mem_ptr_unit u_ptr_a (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (ptr_a_write),
    .load_value (ptr_a_in),
    .inc        (ptr_inc),
    .ptr        (mem_ptr_a)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      mover_pkg::ST_IDLE:  if (start) next_state = mover_pkg::ST_ISSUE;
      mover_pkg::ST_ISSUE: next_state = mover_pkg::ST_LOAD;
      mover_pkg::ST_LOAD:  if (bus_ack) next_state = mover_pkg::ST_STORE;
      mover_pkg::ST_STORE: if (bus_ack) next_state = more ? mover_pkg::ST_ISSUE : mover_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state <= mover_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // A request arriving while busy is kept; repeats during one run merge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pending <= 1'b0;
    else
      pending <= act_req | (pending & ~in_idle);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      active_mode <= mover_pkg::MODE_OUT_FIX;
    else if (start)
      active_mode <= mover_control_a;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      byte_sel <= 1'b0;
    else if (start)
      byte_sel <= 1'b0;
    else if (more)
      byte_sel <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      io_ptr <= mover_pkg::COUNT_RESET;
    else if (ptr_b_write)
      io_ptr <= mem_ptr_b_low;
  end

  // Decrement beats a software write landing in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      transfer_count_reg <= mover_pkg::COUNT_RESET;
    else if (finish)
      transfer_count_reg <= 8'(transfer_count_reg - 8'h01);
    else if (count_write)
      transfer_count_reg <= count_value;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mover_done_irq <= 1'b0;
    else
      mover_done_irq <= finish & last_one;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_hold <= 1'b0;
      bus_req  <= 1'b0;
    end
    else
    begin
      bus_hold <= next_busy;
      bus_req  <= next_req;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_addr  <= mover_pkg::PTR_RESET;
      bus_wr    <= 1'b0;
      bus_io    <= 1'b0;
      bus_wdata <= mover_pkg::COUNT_RESET;
    end
    else if (state == mover_pkg::ST_ISSUE)
    begin
      bus_addr <= src_addr;
      bus_wr   <= 1'b0;
      bus_io   <= step.io_to_mem;
    end
    else if (load_ack)
    begin
      bus_addr  <= dst_addr;
      bus_wr    <= 1'b1;
      bus_io    <= ~step.io_to_mem;
      bus_wdata <= bus_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_store_ack;
    (state == mover_pkg::ST_STORE) && bus_ack;
  endsequence

  sequence s_load_ack;
    (state == mover_pkg::ST_LOAD) && bus_ack;
  endsequence

  property p_ignore_zero;
    in_idle && (transfer_count_reg == mover_pkg::COUNT_RESET) && !count_write |=> in_idle && !bus_hold;
  endproperty
  a_ignore_zero: assert property (p_ignore_zero) else $error("started with zero count");

  property p_start;
    in_idle && pending && count_ok && step.valid_mode |=> (state == mover_pkg::ST_ISSUE) ##1 bus_req && !bus_wr;
  endproperty
  a_start: assert property (p_start) else $error("activation not served");

  property p_io_page;
    bus_req && bus_io |-> bus_addr[17:8] == mover_pkg::IO_PAGE;
  endproperty
  a_io_page: assert property (p_io_page) else $error("I/O access off page");

  property p_load_then_store;
    s_load_ack |=> bus_req && bus_wr && (bus_wdata == $past(bus_rdata)) && (state == mover_pkg::ST_STORE);
  endproperty
  a_load_then_store: assert property (p_load_then_store) else $error("store missing after load");

  property p_fixed_ptr;
    s_store_ack ##0 (active_mode[3:1] == 3'h0) && !ptr_a_write |=> $stable(mem_ptr_a);
  endproperty
  a_fixed_ptr: assert property (p_fixed_ptr) else $error("pointer moved in fixed mode");

  property p_inc_one;
    s_store_ack ##0 ((active_mode == mover_pkg::MODE_OUT_INC) || (active_mode == mover_pkg::MODE_IN_INC))
      |=> mem_ptr_a == 18'($past(mem_ptr_a) + 18'h0_0001);
  endproperty
  a_inc_one: assert property (p_inc_one) else $error("pointer not stepped by one");

  property p_odd_second;
    bus_req && bus_io && byte_sel && (active_mode[3:1] == 3'h2) |-> bus_addr[7:0] == 8'(io_ptr + 8'h01);
  endproperty
  a_odd_second: assert property (p_odd_second) else $error("second word byte not at odd address");

  property p_swap_dir;
    s_load_ack ##0 (active_mode[3:1] == 3'h3) |=> bus_io == byte_sel;
  endproperty
  a_swap_dir: assert property (p_swap_dir) else $error("exchange direction wrong");

  property p_hold_second;
    s_store_ack ##0 (active_mode == mover_pkg::MODE_SWAP_HOLD) && byte_sel && !ptr_a_write |=> $stable(mem_ptr_a);
  endproperty
  a_hold_second: assert property (p_hold_second) else $error("pointer moved after second byte");

  property p_back_to_back;
    s_store_ack ##0 step.two_bytes && !byte_sel |=> bus_hold && (state == mover_pkg::ST_ISSUE) ##1 bus_req;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("bus released between bytes");

  property p_irq_count;
    mover_done_irq |-> (transfer_count_reg == mover_pkg::COUNT_RESET) && $past(finish);
  endproperty
  a_irq_count: assert property (p_irq_count) else $error("done pulse without final transfer");

  property p_word_step;
    s_store_ack ##0 (active_mode[3:1] == 3'h2)
      |=> mem_ptr_a == 18'($past(mem_ptr_a) + 18'h0_0001);
  endproperty
  a_word_step: assert property (p_word_step) else $error("word byte did not step pointer");

  property p_swap_adv;
    s_store_ack ##0 (active_mode == mover_pkg::MODE_SWAP_ADV)
      |=> mem_ptr_a == 18'($past(mem_ptr_a) + 18'h0_0001);
  endproperty
  a_swap_adv: assert property (p_swap_adv) else $error("exchange byte did not step pointer");

  // Software must not rewrite the pointer mid-activation, or this fires
  property p_mem_addr;
    bus_req && !bus_io |-> bus_addr == mem_ptr_a;
  endproperty
  a_mem_addr: assert property (p_mem_addr) else $error("memory access off pointer");

  property p_count_step;
    finish |=> transfer_count_reg == 8'($past(transfer_count_reg) - 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count not stepped once per activation");

  property p_release;
    finish |=> in_idle && !bus_hold && !bus_req;
  endproperty
  a_release: assert property (p_release) else $error("bus kept after activation");

endmodule : auto_byte_mover

//--- src/mem_ptr_unit.sv
// Eighteen-bit memory pointer with load and increment by one.
// Assumes the sequencer never loads and increments in the same cycle on purpose.
`timescale 1ns/1ps
module mem_ptr_unit (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Control
  input  wire logic        load,
  input  wire logic [17:0] load_value,
  input  wire logic        inc,
  // Pointer
  output logic      [17:0] ptr
);

  // Increment wins over a load so a byte in flight never loses its step
  wire [17:0] next_ptr = inc ? 18'(ptr + 18'h0_0001) : load_value;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ptr <= mover_pkg::PTR_RESET;
    else if (inc | load)
      ptr <= next_ptr;
  end

endmodule : mem_ptr_unit

//--- src/mover_pkg.sv
// Constants, mode codes and state codes for the automatic byte mover.
// Assumes one core clock and a single core bus shared with the processor.
package mover_pkg;

  localparam int          ADDR_W      = 18;
  localparam int          BYTE_W      = 8;
  localparam int          MODE_W      = 4;
  localparam int          IO_PAGE_W   = 10;

  // Upper ten address bits forced onto every I/O side access
  localparam logic [9:0]  IO_PAGE     = 10'h03F;

  localparam logic [17:0] PTR_RESET   = 18'h0_0000;
  localparam logic [7:0]  COUNT_RESET = 8'h00;
  localparam logic [7:0]  COUNT_LAST  = 8'h01;

  // Mode codes handled here; codes 8 to F belong elsewhere
  localparam logic [3:0]  MODE_OUT_FIX   = 4'h0;
  localparam logic [3:0]  MODE_IN_FIX    = 4'h1;
  localparam logic [3:0]  MODE_OUT_INC   = 4'h2;
  localparam logic [3:0]  MODE_IN_INC    = 4'h3;
  localparam logic [3:0]  MODE_WORD_OUT  = 4'h4;
  localparam logic [3:0]  MODE_WORD_IN   = 4'h5;
  localparam logic [3:0]  MODE_SWAP_ADV  = 4'h6;
  localparam logic [3:0]  MODE_SWAP_HOLD = 4'h7;
  localparam int          MODE_HIGH_BIT  = 3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_LOAD  = 2'b10,
    ST_STORE = 2'b11
  } state_t;

endpackage : mover_pkg

//--- src/mover_step_if.sv
// Per-byte step description passed between sequencer and mode decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface mover_step_if;
  logic [3:0] mode;
  logic       second_byte;
  logic       valid_mode;
  logic       two_bytes;
  logic       io_to_mem;
  logic       io_odd;
  logic       inc_after;

  modport decoder (
    input  mode,
    input  second_byte,
    output valid_mode,
    output two_bytes,
    output io_to_mem,
    output io_odd,
    output inc_after
  );

  modport sequencer (
    output mode,
    output second_byte,
    input  valid_mode,
    input  two_bytes,
    input  io_to_mem,
    input  io_odd,
    input  inc_after
  );
endinterface : mover_step_if

//--- src/step_decode.sv
// Mode decoder: direction, I/O odd offset and pointer step for each byte.
// Assumes mode and byte index are stable while the sequencer uses the result.
`timescale 1ns/1ps
module step_decode (
  // Step description
  mover_step_if.decoder step
);

  wire m_swap = (step.mode == mover_pkg::MODE_SWAP_ADV) | (step.mode == mover_pkg::MODE_SWAP_HOLD);
  wire m_word = (step.mode == mover_pkg::MODE_WORD_OUT) | (step.mode == mover_pkg::MODE_WORD_IN);

  assign step.valid_mode = ~step.mode[mover_pkg::MODE_HIGH_BIT];
  assign step.two_bytes  = m_word | m_swap;
  assign step.io_to_mem  = (step.mode == mover_pkg::MODE_IN_FIX)
                         | (step.mode == mover_pkg::MODE_IN_INC)
                         | (step.mode == mover_pkg::MODE_WORD_IN)
                         | (m_swap & ~step.second_byte);
  assign step.io_odd     = m_word & step.second_byte;
  assign step.inc_after  = (step.mode == mover_pkg::MODE_OUT_INC)
                         | (step.mode == mover_pkg::MODE_IN_INC)
                         | m_word
                         | (step.mode == mover_pkg::MODE_SWAP_ADV)
                         | ((step.mode == mover_pkg::MODE_SWAP_HOLD) & ~step.second_byte);

endmodule : step_decode

//--- tb/core_bus_model.sv
// Core bus stand-in: memory and I/O page, each access answered by a one-cycle ack.
// Assumes the mover holds its request and qualifiers until it samples the ack.
`timescale 1ns/1ps
module core_bus_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Answer delay in cycles
  input  wire logic [1:0]  lat,
  // Core bus
  input  wire logic        bus_req,
  input  wire logic        bus_wr,
  input  wire logic [17:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_io,
  output logic             bus_ack,
  output logic      [7:0]  bus_rdata
);
  logic [7:0]  mem [logic [17:0]];
  logic [27:0] log_q [$];
  logic [1:0]  wait_cnt;
  logic [7:0]  rd;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      bus_rdata <= 8'h00;
    end
    else if (bus_ack)
    begin
      // Read data is only valid with the ack; scramble it so stale use shows
      bus_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      bus_rdata <= ~bus_rdata;
    end
    else if (bus_req && wait_cnt >= lat)
    begin
      rd = mem.exists(bus_addr) ? mem[bus_addr] : (bus_addr[7:0] ^ 8'h5A);
      bus_ack <= 1'b1;
      if (bus_wr)
        mem[bus_addr] = bus_wdata;
      else
        bus_rdata <= rd;
      log_q.push_back({bus_io, bus_wr, bus_addr, bus_wr ? bus_wdata : rd});
    end
    else if (bus_req)
      wait_cnt <= wait_cnt + 2'h1;
  end
endmodule : core_bus_model

//--- tb/testbench.sv
// Self-checking bench for the byte mover, modes 0 to 7, against a bus stand-in.
// Assumes the designer's timing: activation taken one edge after act_req is driven.
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  mover_control_a = 4'h0;
  logic        ptr_a_write = 1'b0;
  logic [17:0] ptr_in = 18'h0_0000;
  logic        ptr_b_write = 1'b0;
  logic [7:0]  mem_ptr_b_low = 8'h00;
  logic        count_write = 1'b0;
  logic [7:0]  count_value = 8'h00;
  logic        act_req = 1'b0;
  logic [1:0]  lat = 2'h0;
  logic        bus_ack, bus_hold, bus_req, bus_wr, bus_io, mover_done_irq, hold_d;
  logic [7:0]  bus_rdata, bus_wdata, transfer_count_reg;
  logic [17:0] bus_addr, mem_ptr_a;
  logic [7:0]  mirror [logic [17:0]];
  int          n_fail = 0;
  int          check_count = 0;
  int          irq_cnt = 0;
  int          hold_rises = 0;

  always #12.5 clk_sys = ~clk_sys;

  auto_byte_mover dut (
    .clk_sys(clk_sys), .rst(rst), .mover_control_a(mover_control_a),
    .ptr_a_write(ptr_a_write), .mem_ptr_a_high(ptr_in[17:16]), .mem_ptr_a_mid(ptr_in[15:8]),
    .mem_ptr_a_low(ptr_in[7:0]), .ptr_b_write(ptr_b_write), .mem_ptr_b_low(mem_ptr_b_low),
    .count_write(count_write), .count_value(count_value), .act_req(act_req),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_hold(bus_hold), .bus_req(bus_req),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_io(bus_io),
    .mem_ptr_a(mem_ptr_a), .transfer_count_reg(transfer_count_reg), .mover_done_irq(mover_done_irq)
  );

  core_bus_model model (
    .clk_sys(clk_sys), .rst(rst), .lat(lat), .bus_req(bus_req), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_io(bus_io), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata)
  );

  always @(posedge clk_sys)
  begin
    hold_d <= bus_hold;
    if (mover_done_irq === 1'b1)
      irq_cnt++;
    if (bus_hold === 1'b1 && hold_d === 1'b0)
      hold_rises++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("n_fail=%0d check_count=%0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] rdm(input logic [17:0] a);
    return mirror.exists(a) ? mirror[a] : (a[7:0] ^ 8'h5A);
  endfunction : rdm

  task automatic pop_chk(input logic [27:0] exp);
    check(model.log_q.size() > 0 ? model.log_q.pop_front() : 28'hxxx_xxxx, exp);
  endtask : pop_chk

  task automatic setup(input logic [3:0] m, input logic [17:0] p, input logic [7:0] io,
                       input logic [7:0] c);
    @(posedge clk_sys);
    mover_control_a <= m;
    ptr_in          <= p;
    mem_ptr_b_low   <= io;
    count_value     <= c;
    ptr_a_write     <= 1'b1;
    ptr_b_write     <= 1'b1;
    count_write     <= 1'b1;
    @(posedge clk_sys);
    ptr_a_write <= 1'b0;
    ptr_b_write <= 1'b0;
    count_write <= 1'b0;
    #1;
    check(mem_ptr_a, p);
    check(transfer_count_reg, c);
  endtask : setup

  // One activation; the reference pointer p advances as the mover's should
  task automatic fire(input logic [3:0] m, inout logic [17:0] p, input logic [7:0] io, input bit run);
    int          n;
    bit          m2io;
    logic [17:0] ioa, src, dst;
    logic [7:0]  d;
    hold_rises = 0;
    @(posedge clk_sys);
    act_req <= 1'b1;
    @(posedge clk_sys);
    act_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    for (n = 0; n < 80 && bus_hold !== 1'b0; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
    // A run that never releases the bus counts as a mismatch here
    check(bus_hold, 1'b0);
    for (int b = 0; b < (run ? (m >= 4 ? 2 : 1) : 0); b++)
    begin
      ioa  = {mover_pkg::IO_PAGE, io + ((m == 4 || m == 5) ? 8'(b) : 8'h00)};
      m2io = (m == 0 || m == 2 || m == 4 || (m >= 6 && b == 1));
      src  = m2io ? p : ioa;
      dst  = m2io ? ioa : p;
      d    = rdm(src);
      pop_chk({!m2io, 1'b0, src, d});
      pop_chk({m2io, 1'b1, dst, d});
      mirror[dst] = d;
      if (m >= 2 && !(m == 7 && b == 1))
        p = p + 18'h0_0001;
    end
    check(model.log_q.size(), 0);
    check(mem_ptr_a, p);
    check(hold_rises, run ? 1 : 0);
  endtask : fire

  // Every mode, two activations then one refused; latency varies per mode
  task automatic modes_scan;
    logic [17:0] p;
    logic [7:0]  io;
    for (int m = 0; m < 8; m++)
    begin
      lat = 2'(m);
      p   = {m[0], 1'b0, 16'hFFFF};
      // Even offset for word modes; for 6 and 7 it stands in for the serial shift buffer
      io  = 8'h10 + 8'(2 * m);
      setup(4'(m), p, io, 8'h02);
      fire(4'(m), p, io, 1'b1);
      check(transfer_count_reg, 8'h01);
      check(irq_cnt, 0);
      fire(4'(m), p, io, 1'b1);
      check(transfer_count_reg, 8'h00);
      check(irq_cnt, 1);
      fire(4'(m), p, io, 1'b0);
      check(irq_cnt, 1);
      irq_cnt = 0;
    end
  endtask : modes_scan

  // Codes above 7 are consumed with no bus traffic and no count change
  task automatic high_codes;
    logic [17:0] p;
    for (int m = 8; m < 16; m++)
    begin
      p = 18'h0_0100;
      setup(4'(m), p, 8'h20, 8'h01);
      fire(4'(m), p, 8'h20, 1'b0);
      check(transfer_count_reg, 8'h01);
      check(irq_cnt, 0);
    end
  endtask : high_codes

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    $display("BAD t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(mem_ptr_a, 18'h0_0000);
    check(transfer_count_reg, 8'h00);
    modes_scan();
    high_codes();
    stop_test();
  end
endmodule : testbench
